// ==== hdl/usm_defs.svh ====
// register offsets, bit positions, reset values and timing counts
`ifndef USM_DEFS_SVH
`define USM_DEFS_SVH
`define USM_OFF_DATA     12'h000
`define USM_OFF_INT_EN   12'h004
`define USM_OFF_LINE_CTL 12'h00c
`define USM_OFF_MDM_CTL  12'h010
`define USM_OFF_LN_STAT  12'h014
`define USM_OFF_MDM_STAT 12'h018
`define USM_OFF_SCRATCH  12'h01c
`define USM_OFF_DIV_LO   12'h020
`define USM_OFF_DIV_HI   12'h024
`define USM_OFF_PART_ID  12'h028
`define USM_OFF_PART_REV 12'h02c
`define USM_OFF_ENH      12'h030
`define USM_OFF_XON      12'h034
`define USM_OFF_XOFF     12'h038
`define USM_MC_DTR       0
`define USM_MC_RTS       1
`define USM_MC_RING      2
`define USM_MC_INTEN     3
`define USM_MC_LOOP      4
`define USM_MC_XANY      5
`define USM_MC_PRESC     7
`define USM_MC_ENH_MASK  8'he4
`define USM_EF_ENH       4
`define USM_EF_ACTS      7
`define USM_LC_PEN       3
`define USM_LC_EVEN      4
`define USM_LC_BRK       6
`define USM_IE_RX        0
`define USM_IE_TX        1
`define USM_IE_LINE      2
`define USM_IE_MDM       3
`define USM_RST_BYTE     8'h00
`define USM_RST_SCRATCH  8'hff
`define USM_RST_DIV      16'h0001
`define USM_PRESC_LAST   2'h3
`define USM_OVS_LAST     4'hf
`define USM_OVS_MID      4'h7
`define USM_DATA_LAST    3'h7
`define USM_FRAME_PAR    4'hb
`define USM_FRAME_NOPAR  4'ha
`endif

// ==== hdl/usm_pkg.sv ====
// types shared by the status and modem control block
package usm_pkg;
   typedef struct packed {
      logic cd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } usm_modem_in_s;
   typedef struct packed {
      logic       brk;
      logic       fe;
      logic       pe;
      logic [7:0] data;
   } usm_rx_entry_s;
   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_PAR   = 3'b011,
      RX_STOP  = 3'b100,
      RX_BRK   = 3'b101
   } usm_rx_state_e;
endpackage : usm_pkg

// ==== hdl/usm_uart_regs.sv ====
// uart status and modem control registers with apb slave, rx fifo and tx path
// How it works
// R1 - in loopback, ring status follows modem control bit 2
// R2 - modem control bit 3 enables interrupt output driver in two-strobe mode
// R3 - in loopback, carrier status follows modem control bit 3
// R4 - modem control bit 4 selects loopback, clear after reset
// R5 - xon-any: any received char resumes tx; flow chars not stored; a received xoff with software flow control set still halts tx
// R6 - modem control bit 7 divides baud clock input by four
// R7 - line status bit 0 set while receive fifo holds data
// R8 - char completing with full fifo sets overrun, fifo untouched
// R9 - parity error flag belongs to character at read position
// R10 - framing error flag belongs to character at read position
// R11 - break loads one char, flag held until line idle
// R12 - holding empty sets on hand-over, clears on host write
// R13 - transmitter empty only when holding and shifter both empty
// R14 - line status bit 7 set while any fifo char has error
// R15 - delta bits set on change since last read, raise interrupt
// R16 - ring delta sets only on ring input low to high
// R17 - auto cts: high cts halts after current char, low resumes
// R18 - modem status high bits read inverted pins or loopback sources
// R19 - scratch register resets to all ones
// R20 - baud tick is prescaled clock over 16 and divisor
// R21 - software zeroes divisor before reading identification registers
// R22 - software clears flow control selects before new setting
// R23 - modem control bits 2,5,6,7 writable only with enhanced enable
// R24 - loopback routes tx to rx, external tx held idle
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "usm_defs.svh"
module usm_uart_regs #(
   parameter int          FIFO_DEPTH = 16,
   parameter int          PTR_W      = 4,
   parameter logic [7:0]  PART_ID    = 8'h5a,  // arbitrary value
   parameter logic [7:0]  PART_REV   = 8'h0a   // arbitrary value
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   ce,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output      logic [31:0]            prdata,
   output      logic                   pready,
   output      logic                   pslverr,
   input  wire logic                   single_strobe,
   input  wire logic                   rxd,
   input  wire usm_pkg::usm_modem_in_s modem_in,
   output      logic                   txd,
   output      logic                   rts_n,
   output      logic                   irq,
   output      logic                   irq_oe
);
   import usm_pkg::*;

   // apb access phase, one wait state so answers come from flops
   logic        acc, done, wr, rd;
   logic [7:0]  wb;
   assign acc  = psel & penable;
   assign done = acc & pready;
   assign wr   = done & pwrite;
   assign rd   = done & ~pwrite;
   assign wb   = pwdata[7:0];

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   // control registers
   logic [7:0]  int_en_ff, line_ctl_ff, modem_control_ff, scratch_ff;
   logic [7:0]  enhanced_features_ff, xon_ff, xoff_ff;
   logic [15:0] div_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_en_ff            <= `USM_RST_BYTE;
         line_ctl_ff          <= `USM_RST_BYTE;
         modem_control_ff     <= `USM_RST_BYTE;  // R4
         scratch_ff           <= `USM_RST_SCRATCH;  // R19
         enhanced_features_ff <= `USM_RST_BYTE;
         xon_ff               <= `USM_RST_BYTE;
         xoff_ff              <= `USM_RST_BYTE;
         div_ff               <= `USM_RST_DIV;
      end else if (ce && wr) begin
         if (hit(paddr, `USM_OFF_INT_EN)) begin
            int_en_ff <= wb;
         end else if (hit(paddr, `USM_OFF_LINE_CTL)) begin
            line_ctl_ff <= wb;
         end else if (hit(paddr, `USM_OFF_MDM_CTL)) begin
            // enhanced bits keep their value unless enhanced enable is set
            if (enhanced_features_ff[`USM_EF_ENH]) begin
               modem_control_ff <= wb;
            end else begin
               modem_control_ff <= (wb & ~`USM_MC_ENH_MASK) |
                                   (modem_control_ff & `USM_MC_ENH_MASK);  // R23
            end
         end else if (hit(paddr, `USM_OFF_SCRATCH)) begin
            scratch_ff <= wb;
         end else if (hit(paddr, `USM_OFF_DIV_LO)) begin
            div_ff[7:0] <= wb;
         end else if (hit(paddr, `USM_OFF_DIV_HI)) begin
            div_ff[15:8] <= wb;
         end else if (hit(paddr, `USM_OFF_ENH)) begin
            enhanced_features_ff <= wb;
         end else if (hit(paddr, `USM_OFF_XON)) begin
            xon_ff <= wb;
         end else if (hit(paddr, `USM_OFF_XOFF)) begin
            xoff_ff <= wb;
         end
      end
   end

   logic loop, pen, even;
   assign loop = modem_control_ff[`USM_MC_LOOP];  // R4
   assign pen  = line_ctl_ff[`USM_LC_PEN];
   assign even = line_ctl_ff[`USM_LC_EVEN];

   // baud generator: optional divide by four, then divisor gives 16x tick
   logic [1:0]  presc_ff;
   logic [15:0] bcnt_ff;
   logic        tick_ff;
   logic        presc_hit;
   assign presc_hit = ~modem_control_ff[`USM_MC_PRESC] | (presc_ff == `USM_PRESC_LAST);  // R6
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_ff <= '0;
         bcnt_ff  <= '0;
         tick_ff  <= 1'b0;
      end else if (ce) begin
         presc_ff <= presc_ff + 2'h1;
         tick_ff  <= 1'b0;
         // a zero divisor stops the generator rather than ticking every cycle
         if (presc_hit && div_ff != '0) begin
            if (bcnt_ff >= div_ff - 16'h1) begin
               bcnt_ff <= '0;
               tick_ff <= 1'b1;  // R20
            end else begin
               bcnt_ff <= bcnt_ff + 16'h1;
            end
         end
      end
   end

   // transmit holding register and shifter
   logic [7:0]  thold_ff;
   logic        thold_full_ff, tx_busy_ff, xoff_halt_ff;
   logic [10:0] tsh_ff;
   logic [3:0]  tx_bits_ff, tx_os_ff;
   logic        cts_halt, tx_load, tx_bit;
   assign cts_halt = enhanced_features_ff[`USM_EF_ACTS] &
                     (loop ? ~modem_control_ff[`USM_MC_RTS] : modem_in.cts_n);
   // halts are looked at only between characters, so a frame always completes
   assign tx_load  = thold_full_ff & ~tx_busy_ff & ~cts_halt & ~xoff_halt_ff;  // R17
   assign tx_bit   = tx_busy_ff ? tsh_ff[0] : 1'b1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thold_ff      <= '0;
         thold_full_ff <= 1'b0;
      end else if (ce) begin
         if (wr && hit(paddr, `USM_OFF_DATA)) begin
            thold_ff      <= wb;
            thold_full_ff <= 1'b1;  // R12
         end else if (tx_load) begin
            thold_full_ff <= 1'b0;  // R12
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_busy_ff <= 1'b0;
         tsh_ff     <= '1;
         tx_bits_ff <= '0;
         tx_os_ff   <= '0;
      end else if (ce) begin
         if (tx_load) begin
            tx_busy_ff <= 1'b1;
            tsh_ff     <= {1'b1, pen ? (^thold_ff) ^ ~even : 1'b1, thold_ff, 1'b0};
            tx_bits_ff <= pen ? `USM_FRAME_PAR : `USM_FRAME_NOPAR;
            tx_os_ff   <= '0;
         end else if (tx_busy_ff && tick_ff) begin
            tx_os_ff <= tx_os_ff + 4'h1;
            if (tx_os_ff == `USM_OVS_LAST) begin
               tsh_ff     <= {1'b1, tsh_ff[10:1]};
               tx_bits_ff <= tx_bits_ff - 4'h1;
               if (tx_bits_ff == 4'h1) begin
                  tx_busy_ff <= 1'b0;
               end
            end
         end
      end
   end

   // receiver, fed from the transmitter in loopback
   logic          rx_line;
   usm_rx_state_e rx_st_ff;
   logic [3:0]    rx_os_ff;
   logic [2:0]    rx_bit_ff;
   logic [7:0]    rx_sh_ff;
   logic          rx_par_ff, rx_zero_ff, rx_done_ff;
   usm_rx_entry_s rx_ent_ff;
   assign rx_line = loop ? tx_bit : rxd;  // R24
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_ff   <= RX_IDLE;
         rx_os_ff   <= '0;
         rx_bit_ff  <= '0;
         rx_sh_ff   <= '0;
         rx_par_ff  <= 1'b0;
         rx_zero_ff <= 1'b0;
         rx_done_ff <= 1'b0;
         rx_ent_ff  <= '0;
      end else if (ce) begin
         rx_done_ff <= 1'b0;
         if (tick_ff) begin
            rx_os_ff <= rx_os_ff + 4'h1;
            case (rx_st_ff)
               RX_IDLE: begin
                  rx_os_ff <= '0;
                  if (!rx_line) begin
                     rx_st_ff   <= RX_START;
                     rx_zero_ff <= 1'b1;
                  end
               end
               RX_START: begin
                  if (rx_os_ff == `USM_OVS_MID) begin
                     rx_os_ff  <= '0;
                     rx_bit_ff <= '0;
                     rx_st_ff  <= rx_line ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (rx_os_ff == `USM_OVS_LAST) begin
                     rx_sh_ff   <= {rx_line, rx_sh_ff[7:1]};
                     rx_zero_ff <= rx_zero_ff & ~rx_line;
                     rx_bit_ff  <= rx_bit_ff + 3'h1;
                     if (rx_bit_ff == `USM_DATA_LAST) begin
                        rx_st_ff <= pen ? RX_PAR : RX_STOP;
                     end
                  end
               end
               RX_PAR: begin
                  if (rx_os_ff == `USM_OVS_LAST) begin
                     rx_par_ff  <= rx_line;
                     rx_zero_ff <= rx_zero_ff & ~rx_line;
                     rx_st_ff   <= RX_STOP;
                  end
               end
               RX_STOP: begin
                  if (rx_os_ff == `USM_OVS_LAST) begin
                     rx_done_ff     <= 1'b1;
                     rx_ent_ff.data <= rx_sh_ff;
                     rx_ent_ff.pe   <= pen & ((^{rx_sh_ff, rx_par_ff}) == even);  // R9
                     rx_ent_ff.fe   <= ~rx_line;  // R10
                     rx_ent_ff.brk  <= rx_zero_ff & ~rx_line;  // R11
                     // a break frame enters the fifo once, then waits for idle
                     rx_st_ff       <= (rx_zero_ff & ~rx_line) ? RX_BRK : RX_IDLE;
                  end
               end
               RX_BRK: begin
                  if (rx_line) begin
                     rx_st_ff <= RX_IDLE;  // R11
                  end
               end
               default: rx_st_ff <= RX_IDLE;
            endcase
         end
      end
   end

   // software flow control on received characters
   logic sw_rx, is_xon, is_xoff, rx_flow_char;
   assign sw_rx        = enhanced_features_ff[1:0] != 2'b00;
   assign is_xon       = rx_ent_ff.data == xon_ff;
   assign is_xoff      = rx_ent_ff.data == xoff_ff;
   assign rx_flow_char = sw_rx & (is_xon | is_xoff);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xoff_halt_ff <= 1'b0;
      end else if (ce && rx_done_ff) begin
         if (sw_rx && is_xoff) begin
            xoff_halt_ff <= 1'b1;
         end else if ((sw_rx && is_xon) || modem_control_ff[`USM_MC_XANY]) begin
            xoff_halt_ff <= 1'b0;  // R5
         end
      end
   end

   // receive fifo with a running count of entries carrying an error
   usm_rx_entry_s            mem [FIFO_DEPTH];
   logic [PTR_W-1:0]         wp_ff, rp_ff;
   logic [PTR_W:0]           cnt_ff, err_cnt_ff;
   logic                     full, push, pop, push_err, pop_err;
   usm_rx_entry_s            head;
   assign full     = cnt_ff == (PTR_W+1)'(FIFO_DEPTH);
   assign push     = rx_done_ff & ~rx_flow_char & ~full;  // R5
   assign pop      = rd & hit(paddr, `USM_OFF_DATA) & (cnt_ff != '0);
   assign head     = (cnt_ff != '0) ? mem[rp_ff] : '0;
   assign push_err = push & (rx_ent_ff.pe | rx_ent_ff.fe | rx_ent_ff.brk);
   assign pop_err  = pop & (head.pe | head.fe | head.brk);
   always_ff @(posedge pclk) begin
      if (ce && push) begin
         mem[wp_ff] <= rx_ent_ff;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_ff      <= '0;
         rp_ff      <= '0;
         cnt_ff     <= '0;
         err_cnt_ff <= '0;
      end else if (ce) begin
         wp_ff      <= wp_ff + PTR_W'(push);
         rp_ff      <= rp_ff + PTR_W'(pop);
         cnt_ff     <= cnt_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
         err_cnt_ff <= err_cnt_ff + (PTR_W+1)'(push_err) - (PTR_W+1)'(pop_err);  // R14
      end
   end

   // overrun flag, cleared by reading line status; a new overrun wins
   logic ovr_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovr_ff <= 1'b0;
      end else if (ce) begin
         if (rx_done_ff && !rx_flow_char && full) begin
            ovr_ff <= 1'b1;  // R8
         end else if (rd && hit(paddr, `USM_OFF_LN_STAT)) begin
            ovr_ff <= 1'b0;
         end
      end
   end

   logic [7:0] line_status;
   assign line_status = {err_cnt_ff != '0,  // R14
                         ~thold_full_ff & ~tx_busy_ff,  // R13
                         ~thold_full_ff,  // R12
                         head.brk | (rx_st_ff == RX_BRK),  // R11
                         head.fe,  // R10
                         head.pe,  // R9
                         ovr_ff,  // R8
                         cnt_ff != '0};  // R7

   // modem status levels and deltas since the last read
   logic [3:0] lvl, lvl_q_ff, delta_ff;
   logic       lvl_ok_ff;
   assign lvl = loop ? {modem_control_ff[`USM_MC_INTEN],  // R3
                        modem_control_ff[`USM_MC_RING],  // R1
                        modem_control_ff[`USM_MC_DTR],
                        modem_control_ff[`USM_MC_RTS]}  // R18
                     : ~{modem_in.cd_n, modem_in.ri_n, modem_in.dsr_n, modem_in.cts_n};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_q_ff  <= '0;
         lvl_ok_ff <= 1'b0;
         delta_ff  <= '0;
      end else if (ce) begin
         lvl_q_ff  <= lvl;
         lvl_ok_ff <= 1'b1;
         // a change seen in the read cycle survives the clear
         for (int i = 0; i < 4; i++) begin
            if (lvl_ok_ff && ((i == 2) ? (lvl_q_ff[i] & ~lvl[i])  // R16
                                       : (lvl_q_ff[i] ^ lvl[i]))) begin
               delta_ff[i] <= 1'b1;  // R15
            end else if (rd && hit(paddr, `USM_OFF_MDM_STAT)) begin
               delta_ff[i] <= 1'b0;
            end
         end
      end
   end

   // read mux, unmapped addresses answer with an error
   logic [7:0] rbyte;
   logic       rmiss;
   always_comb begin
      rbyte = '0;
      rmiss = 1'b0;
      if (hit(paddr, `USM_OFF_DATA)) begin
         rbyte = head.data;
      end else if (hit(paddr, `USM_OFF_INT_EN)) begin
         rbyte = int_en_ff;
      end else if (hit(paddr, `USM_OFF_LINE_CTL)) begin
         rbyte = line_ctl_ff;
      end else if (hit(paddr, `USM_OFF_MDM_CTL)) begin
         rbyte = modem_control_ff;
      end else if (hit(paddr, `USM_OFF_LN_STAT)) begin
         rbyte = line_status;
      end else if (hit(paddr, `USM_OFF_MDM_STAT)) begin
         rbyte = {lvl, delta_ff};  // R18
      end else if (hit(paddr, `USM_OFF_SCRATCH)) begin
         rbyte = scratch_ff;
      end else if (hit(paddr, `USM_OFF_DIV_LO)) begin
         rbyte = div_ff[7:0];
      end else if (hit(paddr, `USM_OFF_DIV_HI)) begin
         rbyte = div_ff[15:8];
      end else if (hit(paddr, `USM_OFF_PART_ID)) begin
         rbyte = (div_ff == '0) ? PART_ID : 8'h00;  // R21
      end else if (hit(paddr, `USM_OFF_PART_REV)) begin
         rbyte = (div_ff == '0) ? PART_REV : 8'h00;  // R21
      end else if (hit(paddr, `USM_OFF_ENH)) begin
         rbyte = enhanced_features_ff;
      end else if (hit(paddr, `USM_OFF_XON) || hit(paddr, `USM_OFF_XOFF)) begin
         rbyte = '0;  // flow characters are write only
      end else begin
         rmiss = 1'b1;
      end
   end

   // apb answer one cycle after the access phase starts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= acc & ~pready;
         pslverr <= acc & ~pready & rmiss;
         if (acc && !pready) begin
            prdata <= pwrite ? 32'h0 : {24'h0, rbyte};
         end
      end
   end

   // serial and interrupt pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txd    <= 1'b1;
         rts_n  <= 1'b1;
         irq    <= 1'b0;
         irq_oe <= 1'b0;
      end else if (ce) begin
         // external line idles high while looped back
         txd    <= loop | (tx_bit & ~line_ctl_ff[`USM_LC_BRK]);  // R24
         rts_n  <= loop | ~modem_control_ff[`USM_MC_RTS];
         irq    <= (int_en_ff[`USM_IE_RX] & line_status[0]) |
                   (int_en_ff[`USM_IE_TX] & line_status[5]) |
                   (int_en_ff[`USM_IE_LINE] & (|line_status[4:1])) |
                   (int_en_ff[`USM_IE_MDM] & (|delta_ff));  // R15
         // single-strobe buses always drive the pin; software leaves bit 3 clear
         irq_oe <= single_strobe | modem_control_ff[`USM_MC_INTEN];  // R2
      end
   end
endmodule : usm_uart_regs

// ==== verif/usm_uart_regs_chk.sv ====
// concurrent checks on the apb handshake and the modem pins
`timescale 1ns/1ps
module usm_uart_regs_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        single_strobe,
   input wire logic        txd,
   input wire logic        rts_n,
   input wire logic        irq_oe
);
   logic [4:0] mc_ff;
   // bits 0,1,3,4 are always writable, so a bus mirror of them is exact
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mc_ff <= 5'h00;
      end else if (ce && psel && penable && pready && pwrite && paddr == 12'h010) begin
         mc_ff <= pwdata[4:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   rdy_one_wait_a: assert property (ce && psel && penable && !pready |=> pready)
      else $error("pready missing after access");
   rdy_pulse_a: assert property (pready |=> !pready) else $error("pready held");
   setup_no_rdy_a: assert property (psel && !penable |-> !pready) else $error("early pready");
   rdy_in_access_a: assert property (pready |-> psel && penable) else $error("stray pready");
   err_with_rdy_a: assert property (pslverr |-> pready) else $error("stray pslverr");
   err_rd_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read data not zero");
   irq_drive_a: assert property ($past(presetn) && $past(ce) |->
         irq_oe == $past(single_strobe | mc_ff[3]))
      else $error("irq enable wrong");
   loop_tx_idle_a: assert property ($past(mc_ff[4]) && mc_ff[4] |-> txd)
      else $error("txd active in loopback");
   rts_follow_a: assert property ($past(presetn) |-> rts_n == $past(!mc_ff[1] | mc_ff[4]))
      else $error("rts_n wrong");
   cover property (pslverr);
   cover property (mc_ff[4] && pready && pwrite);
   cover property (single_strobe && irq_oe);
endmodule : usm_uart_regs_chk

// ==== verif/usm_line_partner.sv ====
// remote serial device: drives the receive line and the modem inputs
`timescale 1ns/1ps
module usm_line_partner #(
   parameter int BIT_CYC = 16
) (
   input wire logic               pclk,
   output logic                   rxd,
   output usm_pkg::usm_modem_in_s modem_in
);
   import usm_pkg::*;
   // line idles high, modem inputs inactive
   initial begin
      rxd = 1'b1;
      modem_in = 4'hf;
   end
   task automatic set_modem(input usm_modem_in_s m);
      modem_in <= m;
   endtask : set_modem
   // start, eight bits lsb first, stop; stop 0 makes a bad frame
   task automatic send(input logic [7:0] b, input logic stop);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (BIT_CYC) @(posedge pclk);
      end
      rxd <= 1'b1;
   endtask : send
endmodule : usm_line_partner

// ==== verif/usm_uart_regs_tb.sv ====
// self-checking bench for the status and modem control registers
`timescale 1ns/1ps
`include "usm_defs.svh"
module usm_uart_regs_tb;
   import usm_pkg::*;
   localparam logic [7:0] ID = 8'h3c;  // arbitrary value
   localparam logic [7:0] REV = 8'h07; // arbitrary value
   logic          pclk, presetn, ce, psel, penable, pwrite, single_strobe;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, r;
   logic          pready, pslverr, rxd, txd, rts_n, irq, irq_oe, e;
   logic [7:0]    v, rxq[$];
   usm_modem_in_s modem_in;
   int            fail_count, tests_run;
   usm_uart_regs #(.PART_ID(ID), .PART_REV(REV)) usm_uart_regs_inst (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .single_strobe(single_strobe), .rxd(rxd), .modem_in(modem_in),
      .txd(txd), .rts_n(rts_n), .irq(irq), .irq_oe(irq_oe));
   usm_line_partner usm_line_partner_inst (.pclk(pclk), .rxd(rxd), .modem_in(modem_in));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] x, input logic [31:0] got);
      tests_run++;
      if (got !== x) begin
         fail_count++;
         $display("[FAIL] %0t exp %h got %h", $time, x, got);
      end
   endtask : chk
   // one apb transfer; the edge before setup keeps drives one per time step
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) begin
         fail_count++;
         finish_test();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [7:0] x);
      apb(1'b0, a, 8'h00);
      chk({24'h0, x}, r);
   endtask : rd
   // bounded poll until a character is ready
   task automatic wait_rx();
      int k;
      k = 0;
      do begin
         apb(1'b0, `USM_OFF_LN_STAT, 8'h00);
         k++;
      end while (r[0] !== 1'b1 && k < 100);
      if (k == 100) begin
         fail_count++;
         finish_test();
      end
   endtask : wait_rx
   initial begin
      {ce, presetn, psel, penable, pwrite, single_strobe} = 6'h20;
      paddr = 12'h000;
      pwdata = 32'h0;
      fail_count = 0;
      tests_run = 0;
      v = 8'($urandom(32'h83e1fa1a));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(`USM_OFF_SCRATCH, 8'hff);
      rd(`USM_OFF_MDM_CTL, 8'h00);
      rd(`USM_OFF_LN_STAT, 8'h60);
      rd(`USM_OFF_MDM_STAT, 8'h00);
      v = 8'($urandom);
      apb(1'b1, `USM_OFF_SCRATCH, v);
      rd(`USM_OFF_SCRATCH, v);
      apb(1'b0, 12'hffc, 8'h00);
      chk(32'h1, {31'h0, e});
      apb(1'b1, `USM_OFF_DIV_LO, 8'h00);
      rd(`USM_OFF_PART_ID, ID);
      rd(`USM_OFF_PART_REV, REV);
      apb(1'b1, `USM_OFF_DIV_LO, 8'h01);
      $display("test reset and identity done");
      apb(1'b1, `USM_OFF_MDM_CTL, 8'hff);
      rd(`USM_OFF_MDM_CTL, 8'h1b);
      rd(`USM_OFF_MDM_STAT, 8'hbb);
      apb(1'b1, `USM_OFF_ENH, 8'h10);
      apb(1'b1, `USM_OFF_MDM_CTL, 8'h1f);
      rd(`USM_OFF_MDM_STAT, 8'hf0);
      apb(1'b1, `USM_OFF_MDM_CTL, 8'h1b);
      rd(`USM_OFF_MDM_STAT, 8'hb4);
      v = 8'($urandom);
      apb(1'b1, `USM_OFF_DATA, v);
      apb(1'b0, `USM_OFF_LN_STAT, 8'h00);
      chk(32'h0, r & 32'h40);
      wait_rx();
      rd(`USM_OFF_DATA, v);
      rd(`USM_OFF_LN_STAT, 8'h60);
      $display("test loopback done");
      apb(1'b1, `USM_OFF_ENH, 8'h90);
      apb(1'b1, `USM_OFF_MDM_CTL, 8'h19);
      apb(1'b1, `USM_OFF_DATA, ~v);
      for (int i = 0; i < 50; i++) apb(1'b0, `USM_OFF_LN_STAT, 8'h00);
      chk(32'h00, r & 32'h61);
      apb(1'b1, `USM_OFF_MDM_CTL, 8'h1b);
      wait_rx();
      rd(`USM_OFF_DATA, ~v);
      $display("test auto cts done");
      apb(1'b1, `USM_OFF_MDM_CTL, 8'h00);
      apb(1'b1, `USM_OFF_ENH, 8'h00);
      apb(1'b0, `USM_OFF_MDM_STAT, 8'h00);
      for (int i = 0; i < 2; i++) begin
         rxq.push_back(8'($urandom) | 8'h01);
         usm_line_partner_inst.send(rxq[i], i == 0);
         wait_rx();
         chk({24'h0, (i == 0) ? 8'h01 : 8'h81}, r & 32'h8f);
      end
      rd(`USM_OFF_DATA, rxq.pop_front());
      rd(`USM_OFF_LN_STAT, 8'he9);
      rd(`USM_OFF_DATA, rxq.pop_front());
      rd(`USM_OFF_LN_STAT, 8'h60);
      usm_line_partner_inst.send(8'h00, 1'b0);
      rd(`USM_OFF_LN_STAT, 8'hf9);
      rd(`USM_OFF_DATA, 8'h00);
      $display("test receive done");
      apb(1'b1, `USM_OFF_INT_EN, 8'h08);
      usm_line_partner_inst.set_modem(4'he);
      rd(`USM_OFF_MDM_STAT, 8'h11);
      chk(32'h1, {31'h0, irq});
      usm_line_partner_inst.set_modem(4'hb);
      rd(`USM_OFF_MDM_STAT, 8'h41);
      usm_line_partner_inst.set_modem(4'hf);
      rd(`USM_OFF_MDM_STAT, 8'h04);
      {ce, single_strobe} <= 2'h1;
      repeat (3) @(posedge pclk);
      chk(32'h0, {31'h0, irq_oe});
      ce <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(32'h1, {31'h0, irq_oe});
      $display("test modem done");
      finish_test();
   end
endmodule : usm_uart_regs_tb
bind usm_uart_regs usm_uart_regs_chk usm_uart_regs_chk_inst (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .single_strobe(single_strobe), .txd(txd), .rts_n(rts_n),
   .irq_oe(irq_oe));
